// ### ipr_host_model.sv
`timescale 1ns/1ps
module ipr_host_model (
    // pin two as seen by the host
    input wire logic pin_two_o,
    input wire logic pin_two_oe_o,
    input wire logic drive_en_i,
    input wire logic drive_val_i,
    output logic wire_o
);
    // pull-up on the line, so a released pin never reads as a stale value
    assign wire_o = pin_two_oe_o ? pin_two_o : (drive_en_i ? drive_val_i : 1'b1);
endmodule

// ### ipr_monitor.sv
`timescale 1ns/1ps
module ipr_monitor (
    // clock, reset, bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // sources and pins
    input wire logic boot_done_event_i,
    input wire logic [7:0] source_enable_i,
    input wire logic boot_strap_select_i,
    input wire logic interrupt_pin_one_o,
    input wire logic interrupt_pin_two_i,
    input wire logic interrupt_pin_two_o,
    input wire logic interrupt_pin_two_oe_o,
    input wire logic ext_trigger_o,
    input wire logic soft_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_follow: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_upper: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_quiet_pins: assert property (source_enable_i == 8'h00 && !boot_strap_select_i
        |=> !interrupt_pin_two_oe_o || interrupt_pin_one_o == interrupt_pin_two_o)
        else $error("pins differ with no source enabled");
    a_strap_drive: assert property (boot_strap_select_i [*3] |=> interrupt_pin_two_oe_o)
        else $error("strap mode pin two undriven");
    a_strap_boot: assert property (boot_strap_select_i [*3] ##0 boot_done_event_i
        |=> !interrupt_pin_two_o)
        else $error("boot not on pin two");
    a_strap_idle: assert property (boot_strap_select_i [*3] ##0 !boot_done_event_i
        |=> interrupt_pin_two_o)
        else $error("non-boot event on pin two");
    a_trig_sample: assert property (ext_trigger_o && !boot_strap_select_i
        |-> $past(interrupt_pin_two_i) && !interrupt_pin_two_oe_o)
        else $error("trigger sample wrong");
    a_srst_pulse: assert property (soft_reset_o |=> !soft_reset_o)
        else $error("soft reset pulse too long");
    c_srst: cover property (soft_reset_o);
    c_trig: cover property (ext_trigger_o);
    c_boot: cover property (boot_strap_select_i && !interrupt_pin_two_o);
endmodule

// ### ipr_pkg.sv
package ipr_pkg;
    // word indices; byte address is four times the index
    localparam logic [5:0] IPR_ROUTE_IDX = 6'h21;
    localparam logic [5:0] IPR_CTRL_IDX = 6'h30;
    localparam logic [5:0] IPR_STAT_IDX = 6'h31;
    localparam logic [5:0] IPR_MASK_IDX = 6'h32;
    localparam logic [5:0] IPR_PIN_IDX = 6'h33;
    // source positions, shared by route, status and mask
    localparam int IPR_DRDY_BIT = 7;
    localparam int IPR_BUF_BIT = 6;
    localparam int IPR_OT_BIT = 5;
    localparam int IPR_WT_BIT = 4;
    localparam int IPR_ORIENT_BIT = 3;
    localparam int IPR_ASLP_BIT = 2;
    localparam int IPR_BOOT_BIT = 1;
    localparam int IPR_WAKE_BIT = 0;
    localparam int IPR_NUM_SRC = 8;
    // control fields
    localparam int IPR_POL_BIT = 0;
    localparam int IPR_P2F_BIT = 1;
    localparam int IPR_SRST_BIT = 7;
    // pin state fields
    localparam int IPR_PS_ONE_BIT = 0;
    localparam int IPR_PS_TWO_BIT = 1;
    localparam int IPR_PS_OE_BIT = 2;
    localparam int IPR_PS_STRAP_BIT = 3;
    localparam int IPR_PS_TRIG_BIT = 4;
    // values after reset
    localparam logic [7:0] IPR_ROUTE_RST = 8'h00;
    localparam logic [7:0] IPR_MASK_RST = 8'h00;
    localparam logic [7:0] IPR_STAT_RST = 8'h00;
    localparam logic [1:0] IPR_CTRL_RST = 2'h0;
endpackage

// ### ipr_route_slice.sv
`timescale 1ns/1ps
module ipr_route_slice #(
    parameter bit IS_BOOT = 1'b0
) (
    // source side
    input wire logic src_i,
    input wire logic en_i,
    input wire logic route_i,
    // mode
    input wire logic pin_two_function_i,
    input wire logic boot_strap_select_i,
    // pin side
    output logic to_one_o,
    output logic to_two_o
);
    logic active;
    logic sel_two;
    logic dropped;

    always_comb begin
        if (IS_BOOT && boot_strap_select_i) begin
            // strap fixes boot onto pin two, enable forced
            active = src_i;
            sel_two = 1'b1;
            dropped = 1'b0;
        end else begin
            active = src_i & en_i;
            // trigger input on pin two: a one is read as zero
            sel_two = route_i & ~pin_two_function_i;
            // strap high: only boot may use pin two
            dropped = boot_strap_select_i & route_i;
        end
        to_one_o = active & ~sel_two & ~dropped;
        to_two_o = active & sel_two & ~dropped;
    end
endmodule

// ### ipr_tb_top.sv
`timescale 1ns/1ps
module ipr_tb_top;
    import ipr_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, boot_strap_select_i;
    logic interrupt_pin_one_o, interrupt_pin_two_i, interrupt_pin_two_o;
    logic interrupt_pin_two_oe_o, ext_trigger_o, soft_reset_o, irq_o, drv_en, drv_val;
    logic [7:0] wb_adr_i, src, en, q;
    logic [2:0] bsel;
    logic [3:0] wb_sel_i, wsel;
    logic [31:0] wb_dat_i, wb_dat_o;
    int n_errors, cmp_count;
    ipr_top ipr_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .data_ready_i(src[7]),
        .buffer_overflow_flag_i(src[6] & bsel[0]), .buffer_watermark_flag_i(src[6] & bsel[1]),
        .buffer_gate_error_i(src[6] & bsel[2]), .outside_threshold_i(src[5]),
        .within_threshold_i(src[4]), .orientation_i(src[3]), .auto_sleep_i(src[2]),
        .boot_done_event_i(src[1]), .wake_state_i(src[0]), .source_enable_i(en),
        .boot_strap_select_i, .interrupt_pin_one_o, .interrupt_pin_two_i, .interrupt_pin_two_o,
        .interrupt_pin_two_oe_o, .ext_trigger_o, .soft_reset_o, .irq_o);
    ipr_host_model ipr_host_model_i (.pin_two_o(interrupt_pin_two_o),
        .pin_two_oe_o(interrupt_pin_two_oe_o), .drive_en_i(drv_en), .drive_val_i(drv_val),
        .wire_o(interrupt_pin_two_i));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // master holds the request until ack is sampled, bounded wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_sel_i <= wsel;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        q = wb_dat_o[7:0];
        chk({7'h0, wb_ack_o}, 8'h01);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    task automatic pins(input logic [1:0] e);
        tick(3);
        chk({6'h0, interrupt_pin_one_o, interrupt_pin_two_i}, {6'h0, e});
    endtask
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, drv_en, drv_val, boot_strap_select_i} = '0;
        wb_adr_i = '0;
        wb_dat_i = '0;
        src = '0;
        en = '0;
        bsel = 3'h1;
        wb_sel_i = 4'hf;
        wsel = 4'hf;
        rst_i = 1'b1;
        n_errors = 0;
        cmp_count = 0;
        tick(3);
        rst_i <= 1'b0;
        rd(8'h84, IPR_ROUTE_RST);
        rd(8'hc8, IPR_MASK_RST);
        rd(8'h00, 8'h00);
        wb(1'b1, 8'h84, 8'ha5);
        rd(8'h84, 8'ha5);
        // byte lane zero off: write acked but ignored
        wsel <= 4'he;
        wb(1'b1, 8'h84, 8'h3c);
        wsel <= 4'hf;
        rd(8'h84, 8'ha5);
        wb(1'b1, 8'hc0, 8'h01);
        for (int i = 0; i < 8; i++) begin
            en <= 8'h01 << i;
            src <= 8'h01 << i;
            wb(1'b1, 8'h84, 8'h00);
            pins(2'b10);
            wb(1'b1, 8'h84, 8'h01 << i);
            pins(2'b01);
        end
        src <= 8'hff;
        en <= 8'h00;
        wb(1'b1, 8'h84, 8'h00);
        pins(2'b00);
        en <= 8'hff;
        wb(1'b1, 8'h84, 8'h0f);
        pins(2'b11);
        wb(1'b1, 8'hc0, 8'h00);
        pins(2'b00);
        en <= 8'h40;
        src <= 8'h40;
        bsel <= 3'b110;
        wb(1'b1, 8'h84, 8'h00);
        pins(2'b01);
        en <= 8'hff;
        src <= 8'hff;
        drv_en <= 1'b1;
        wb(1'b1, 8'hc0, 8'h03);
        wb(1'b1, 8'h84, 8'hff);
        pins(2'b10);
        chk({7'h0, interrupt_pin_two_oe_o}, 8'h00);
        drv_val <= 1'b1;
        tick(3);
        chk({7'h0, ext_trigger_o}, 8'h01);
        drv_en <= 1'b0;
        wb(1'b1, 8'hc0, 8'h80);
        tick(1);
        chk({7'h0, soft_reset_o}, 8'h01);
        tick(2);
        rd(8'h84, 8'h02);
        rd(8'hc0, 8'h00);
        src <= 8'h00;
        wb(1'b1, 8'hc4, 8'hff);
        wb(1'b1, 8'hc8, 8'h20);
        src <= 8'h24;
        tick(3);
        chk({7'h0, irq_o}, 8'h01);
        rd(8'hc4, 8'h24);
        wb(1'b1, 8'hc4, 8'h20);
        tick(2);
        chk({7'h0, irq_o}, 8'h00);
        rd(8'hc4, 8'h04);
        // power-on reset with the strap high
        boot_strap_select_i <= 1'b1;
        rst_i <= 1'b1;
        tick(3);
        rst_i <= 1'b0;
        rd(8'h84, 8'h00);
        wb(1'b1, 8'hc0, 8'h01);
        wb(1'b1, 8'h84, 8'hff);
        src <= 8'hfd;
        pins(2'b01);
        src <= 8'hff;
        pins(2'b00);
        // boot stays on pin two with its enable and bit 1 both clear
        en <= 8'h00;
        wb(1'b1, 8'h84, 8'h00);
        pins(2'b00);
        rd(8'hcc, 8'h0c);
        stop_test;
    end
    initial begin
        repeat (4000) @(posedge clk_i);
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test;
    end
endmodule
bind ipr_top ipr_monitor ipr_monitor_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
    .wb_ack_o, .boot_done_event_i, .source_enable_i, .boot_strap_select_i,
    .interrupt_pin_one_o, .interrupt_pin_two_i, .interrupt_pin_two_o,
    .interrupt_pin_two_oe_o, .ext_trigger_o, .soft_reset_o);

// ### ipr_top.sv
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
// Operation
// - routing bit 7 sends enabled data-ready to pin one when 0, pin two when 1.
// - bit 6 routes the buffer event (overflow or watermark or gate error) likewise.
// - bit 5 routes the enabled outside-threshold change event likewise.
// - bit 4 routes the enabled within-threshold change event likewise.
// - bit 3 routes the enabled orientation-change event likewise.
// - bit 2 routes the enabled auto wake/sleep event likewise.
// - bit 1 routes the enabled boot-done event likewise while the strap is low.
// - the boot routing bit keeps its value across a soft reset; power-on reset clears it.
// - with the strap high boot-done always goes to pin two, ignoring bit 1.
// - bit 0 routes the enabled wake-state level to pin one when 0, pin two when 1.
// - while pin two is a trigger input, routing ones are ignored and pin two carries none.
// - with the strap high a non-boot source routed to pin two reaches neither pin.
// - a source reaches a pin only while its enable bit is set, except boot-done with the strap high.
module ipr_top
    import ipr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // event sources
    input wire logic data_ready_i,
    input wire logic buffer_overflow_flag_i,
    input wire logic buffer_watermark_flag_i,
    input wire logic buffer_gate_error_i,
    input wire logic outside_threshold_i,
    input wire logic within_threshold_i,
    input wire logic orientation_i,
    input wire logic auto_sleep_i,
    input wire logic boot_done_event_i,
    input wire logic wake_state_i,
    input wire logic [7:0] source_enable_i,
    // strap
    input wire logic boot_strap_select_i,
    // pins
    output logic interrupt_pin_one_o,
    input wire logic interrupt_pin_two_i,
    output logic interrupt_pin_two_o,
    output logic interrupt_pin_two_oe_o,
    output logic ext_trigger_o,
    output logic soft_reset_o,
    // interrupt
    output logic irq_o
);
    logic [7:0] route_reg, route_next;
    logic [1:0] ctrl_reg, ctrl_next;
    logic [7:0] mask_reg, mask_next;
    logic [7:0] status_reg, status_next;
    logic [7:0] prev_reg, prev_next;
    logic strap_reg, strap_next;
    logic strap_arm_reg, strap_arm_next;
    logic pin1_reg, pin1_next;
    logic pin2_reg, pin2_next;
    logic pin2_oe_reg, pin2_oe_next;
    logic trig_reg, trig_next;
    logic srst_reg, srst_next;
    logic irq_reg, irq_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;

    logic [IPR_NUM_SRC-1:0] src;
    logic [IPR_NUM_SRC-1:0] to_one;
    logic [IPR_NUM_SRC-1:0] to_two;
    logic act_one;
    logic act_two;
    logic req;
    logic wr;
    logic [5:0] idx;
    logic [7:0] pin_state;
    logic [7:0] rd_byte;
    logic soft_reset;

    // source vector in routing-bit order
    always_comb begin
        src = '0;
        src[IPR_DRDY_BIT] = data_ready_i;
        src[IPR_BUF_BIT] = buffer_overflow_flag_i | buffer_watermark_flag_i
            | buffer_gate_error_i;
        src[IPR_OT_BIT] = outside_threshold_i;
        src[IPR_WT_BIT] = within_threshold_i;
        src[IPR_ORIENT_BIT] = orientation_i;
        src[IPR_ASLP_BIT] = auto_sleep_i;
        src[IPR_BOOT_BIT] = boot_done_event_i;
        src[IPR_WAKE_BIT] = wake_state_i;
    end

    // one slice per source; bit i of route steers source i
    genvar g;
    generate
        for (g = 0; g < IPR_NUM_SRC; g++) begin : g_slice
            ipr_route_slice #(
                .IS_BOOT(g == IPR_BOOT_BIT)
            ) u_slice (
                .src_i(src[g]),
                .en_i(source_enable_i[g]),
                .route_i(route_reg[g]),
                .pin_two_function_i(ctrl_reg[IPR_P2F_BIT]),
                .boot_strap_select_i(strap_reg),
                .to_one_o(to_one[g]),
                .to_two_o(to_two[g])
            );
        end
    endgenerate

    assign act_one = |to_one;
    assign act_two = |to_two;

    // bus decode
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    // write lands on the ack edge, where the master samples ack high
    assign wr = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[7:2];
    assign soft_reset = wr && (idx == IPR_CTRL_IDX) && wb_dat_i[IPR_SRST_BIT];

    always_comb begin
        pin_state = '0;
        pin_state[IPR_PS_ONE_BIT] = pin1_reg;
        pin_state[IPR_PS_TWO_BIT] = pin2_reg;
        pin_state[IPR_PS_OE_BIT] = pin2_oe_reg;
        pin_state[IPR_PS_STRAP_BIT] = strap_reg;
        pin_state[IPR_PS_TRIG_BIT] = trig_reg;
    end

    always_comb begin
        case (idx)
            IPR_ROUTE_IDX: rd_byte = route_reg;
            IPR_CTRL_IDX: rd_byte = {6'h00, ctrl_reg};
            IPR_STAT_IDX: rd_byte = status_reg;
            IPR_MASK_IDX: rd_byte = mask_reg;
            IPR_PIN_IDX: rd_byte = pin_state;
            default: rd_byte = 8'h00;
        endcase
    end

    // register and pin next state
    always_comb begin
        route_next = route_reg;
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        status_next = status_reg;
        prev_next = src;
        strap_next = strap_reg;
        strap_arm_next = strap_arm_reg;
        srst_next = soft_reset;
        ack_next = req;
        dat_next = dat_reg;
        if (req && !wb_we_i) begin
            dat_next = {24'h000000, rd_byte};
        end
        if (wr) begin
            case (idx)
                IPR_ROUTE_IDX: route_next = wb_dat_i[7:0];
                IPR_CTRL_IDX: ctrl_next = wb_dat_i[1:0];
                IPR_MASK_IDX: mask_next = wb_dat_i[7:0];
                IPR_STAT_IDX: status_next = status_reg & ~wb_dat_i[7:0];
                default: ;
            endcase
        end
        if (soft_reset) begin
            // boot routing bit survives; other route bits, ctrl, mask and status return to reset, strap re-armed
            route_next = (IPR_ROUTE_RST & ~(8'h01 << IPR_BOOT_BIT))
                | (route_reg & (8'h01 << IPR_BOOT_BIT));
            ctrl_next = IPR_CTRL_RST;
            mask_next = IPR_MASK_RST;
            status_next = IPR_STAT_RST;
            strap_arm_next = 1'b1;
        end
        // set wins over a same-cycle clear
        status_next = status_next | (src & ~prev_reg);
        // strap sampled once after each reset release
        if (strap_arm_reg) begin
            strap_next = boot_strap_select_i;
            strap_arm_next = soft_reset;
        end
        irq_next = |(status_next & mask_next);
    end

    always_comb begin
        pin1_next = ctrl_reg[IPR_POL_BIT] ? act_one : ~act_one;
        trig_next = 1'b0;
        if (strap_reg) begin
            // boot indicator pulses low, fixed
            pin2_oe_next = 1'b1;
            pin2_next = ~act_two;
        end else if (ctrl_reg[IPR_P2F_BIT]) begin
            // pin two is an input: released, sampled as trigger
            pin2_oe_next = 1'b0;
            pin2_next = ~ctrl_reg[IPR_POL_BIT];
            trig_next = interrupt_pin_two_i;
        end else begin
            pin2_oe_next = 1'b1;
            pin2_next = ctrl_reg[IPR_POL_BIT] ? act_two : ~act_two;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_reg <= IPR_ROUTE_RST;
            ctrl_reg <= IPR_CTRL_RST;
            mask_reg <= IPR_MASK_RST;
            status_reg <= IPR_STAT_RST;
            prev_reg <= '0;
            strap_reg <= 1'b0;
            strap_arm_reg <= 1'b1;
            pin1_reg <= 1'b1;
            pin2_reg <= 1'b1;
            pin2_oe_reg <= 1'b0;
            trig_reg <= 1'b0;
            srst_reg <= 1'b0;
            irq_reg <= 1'b0;
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            route_reg <= route_next;
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            status_reg <= status_next;
            prev_reg <= prev_next;
            strap_reg <= strap_next;
            strap_arm_reg <= strap_arm_next;
            pin1_reg <= pin1_next;
            pin2_reg <= pin2_next;
            pin2_oe_reg <= pin2_oe_next;
            trig_reg <= trig_next;
            srst_reg <= srst_next;
            irq_reg <= irq_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign interrupt_pin_one_o = pin1_reg;
    assign interrupt_pin_two_o = pin2_reg;
    assign interrupt_pin_two_oe_o = pin2_oe_reg;
    assign ext_trigger_o = trig_reg;
    assign soft_reset_o = srst_reg;
    assign irq_o = irq_reg;
endmodule
